// ### design/sid_decoder.sv
`timescale 1ns/1ns
`default_nettype none
module sid_decoder
#(
	parameter bit EIGHT_CH = 1'b1
) (
	// system
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	// serial link, clocked by the host
	input  wire logic                  serial_clk,
	input  wire logic                  chip_select_n,
	input  wire logic                  read_only_sel,
	input  wire logic                  power_down_pin,
	input  wire logic                  serial_instruction_in,
	output logic                       serial_data_out,
	// converter side
	input  wire logic                  conversion_clock,
	input  wire logic [12:0]           conv_result,
	input  wire logic                  conv_result_valid,
	output logic                       conv_start,
	output logic [3:0]                 mux_address,
	output logic [5:0]                 acq_cycles,
	output var sid_pkg::sid_cfg_s      config_state,
	output logic                       mux_internal_tie,
	output logic [6:0]                 test_outputs_oe,
	output logic [sid_pkg::STATUS_BITS-1:0] device_status_word
);
	import sid_pkg::*;

	// ---------------- link domain: clocked by serial_clk ----------------
	typedef struct packed {
		logic [7:0]  shift;
		logic [3:0]  cnt;
		logic [16:0] out_word;
		logic        fire;
		sid_instr_s  instr;
	} sid_link_s;

	sid_link_s   lk_r, lk_nxt;
	logic        link_rst_n;
	logic        fifo_ready;
	logic        q_valid;
	logic        q_ready;
	sid_instr_s  q_data;
	logic [16:0] tx_word;

	function automatic sid_instr_s decode(input logic [7:0] d);
		sid_instr_s r;
		logic [3:0] fmt;
		logic [3:0] adr;
		r = '0;
		r.cmd = SID_CMD_NONE;
		adr = EIGHT_CH ? d[3:0] : {2'h0, d[1:0]};
		fmt = EIGHT_CH ? d[7:4] : d[5:2];
		r.addr      = adr;
		r.acq_sel   = {d[0], d[1]}; // first bit is the high code bit
		r.wide      = fmt[3];
		r.lsb_first = fmt[1];
		r.sign_on   = d[0];
		if (!fmt[0] && !fmt[2]) begin
			r.cmd = SID_CMD_CONV;
		end else if (fmt[0] && !fmt[1] && adr == 4'h0) begin
			case (fmt[3:2])
				2'h0:    r.cmd = SID_CMD_CAL;
				2'h2:    r.cmd = SID_CMD_ZERO;
				2'h1:    r.cmd = SID_CMD_PUP;
				default: r.cmd = SID_CMD_PDN;
			endcase
		end else if (fmt == 4'h7 && adr[3:2] == 2'h0) begin
			r.cmd = SID_CMD_ACQ;
		end else if (fmt == 4'h3 && adr == 4'h0) begin
			r.cmd = SID_CMD_STAT;
		end else if (fmt == 4'hb && adr[3:1] == 3'h0) begin
			r.cmd = SID_CMD_SIGN;
		end else if (fmt == 4'hf) begin
			r.cmd = adr[0] ? SID_CMD_TEST :
				(adr == 4'h0 ? SID_CMD_USER : SID_CMD_NONE);
		end
		return r;
	endfunction

	always_comb begin
		lk_nxt = lk_r;
		lk_nxt.fire = 1'b0;
		if (chip_select_n) begin
			lk_nxt.cnt = '0;
		end else begin
			// bit 0 first, so shift toward the low end
			lk_nxt.shift = {serial_instruction_in, lk_r.shift[7:1]};
			lk_nxt.out_word = {lk_r.out_word[15:0], 1'b0};
			// quasi-static: the word only moves between frames in normal
			// use; a status flag flipping right at the first edge may be
			// caught half old, so poll status twice when it matters
			if (lk_r.cnt == 4'h0)
				lk_nxt.out_word = tx_word;
			if (lk_r.cnt != 4'h8)
				lk_nxt.cnt = lk_r.cnt + 4'h1;
			if (lk_r.cnt == 4'h7) begin
				lk_nxt.instr = decode({serial_instruction_in,
					lk_r.shift[7:1]});
				// only decode mode passes the instruction
				lk_nxt.fire = !read_only_sel && !power_down_pin;
			end
		end
	end

	// select high clears the frame state: the serial clock stops between
	// frames, so no edge would be there to restart the bit count
	assign link_rst_n = rst_n && !chip_select_n;

	always_ff @(posedge serial_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			lk_r <= '0;
		end else begin
			lk_r <= lk_nxt;
		end
	end

	assign serial_data_out = lk_r.out_word[16];

	sid_fifo #(
		.WIDTH($bits(sid_instr_s)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.wclk     (serial_clk),
		.wrst_n   (rst_n),
		// written on the eighth edge itself: no later edge may follow
		.in_valid (lk_nxt.fire),
		.in_ready (fifo_ready),
		.in_data  (lk_nxt.instr),
		.rclk     (clk),
		.rrst_n   (rst_n),
		.out_valid(q_valid),
		.out_ready(q_ready),
		.out_data (q_data)
	);

	// ---------------- system domain ----------------
	typedef struct packed {
		sid_cfg_s    cfg;
		logic [3:0]  addr;
		logic        conv_start;
		logic        stat_show;
		logic [16:0] word;
		logic [7:0]  seq_cnt;
		logic        cal_busy;
		logic        pu_busy;
		logic        pd_busy;
		logic [2:0]  pd_sync;
		logic        pd_level;
		logic [2:0]  cc_sync;
		logic        cc_level;
	} sid_sys_s;

	sid_sys_s    st_r, st_nxt;

	function automatic logic [5:0] acq_count(input logic [1:0] s);
		case (s)
			2'h0:    return ACQ_CYC6;
			2'h1:    return ACQ_CYC10;
			2'h2:    return ACQ_CYC18;
			default: return ACQ_CYC34;
		endcase
	endfunction

	// result formatted to the current word shape, first bit sent at bit 16 except in wide MSB-first mode, where the MSB sits at bit 12
	function automatic logic [16:0] fmt_word(input logic [12:0] v,
		input sid_cfg_s c);
		logic [16:0] w;
		logic [11:0] m;
		w = '0;
		m = c.lsb_first ? {<<{v[11:0]}} : v[11:0];
		if (c.lsb_first)
			w = c.sign_on ? {m, v[12], 4'h0} : {m, 5'h00};
		else if (c.wide)
			w = c.sign_on ? {4'h0, v[12], v[11:0]} : {4'h0, v[11:0], 1'b0};
		else
			w = c.sign_on ? {v, 4'h0} : {v[11:0], 5'h00};
		return w;
	endfunction

	logic cc_edge;
	// rising edge of the filtered level, so a sequence counts whole periods
	assign cc_edge = st_r.cc_sync[2] && st_r.cc_sync[1] && !st_r.cc_level;
	assign q_ready = 1'b1;

	always_comb begin
		st_nxt = st_r;
		st_nxt.conv_start = 1'b0;
		st_nxt.pd_sync = {st_r.pd_sync[1:0], power_down_pin};
		st_nxt.cc_sync = {st_r.cc_sync[1:0], conversion_clock};
		if (st_r.pd_sync[2] == st_r.pd_sync[1])
			st_nxt.pd_level = st_r.pd_sync[2];
		if (st_r.cc_sync[2] == st_r.cc_sync[1])
			st_nxt.cc_level = st_r.cc_sync[2];
		if (cc_edge && st_r.seq_cnt != 8'h00)
			st_nxt.seq_cnt = st_r.seq_cnt - 8'h01;
		if (st_r.seq_cnt == 8'h01 && cc_edge) begin
			st_nxt.cal_busy = 1'b0;
			st_nxt.pu_busy  = 1'b0;
			st_nxt.pd_busy  = 1'b0;
		end
		if (conv_result_valid)
			st_nxt.word = fmt_word(conv_result, st_r.cfg);
		if (q_valid) begin
			// status stays on the link until another command arrives
			st_nxt.stat_show = 1'b0;
			case (q_data.cmd)
				SID_CMD_CONV: begin
					st_nxt.addr = q_data.addr;
					st_nxt.cfg.wide = q_data.wide;
					st_nxt.cfg.lsb_first = q_data.lsb_first;
					st_nxt.conv_start = 1'b1;
				end
				SID_CMD_CAL: begin
					st_nxt.cfg.auto_cal = 1'b1;
					st_nxt.cal_busy = 1'b1;
					st_nxt.seq_cnt = SEQ_CYCLES;
				end
				SID_CMD_ZERO: st_nxt.cfg.auto_zero = 1'b1;
				SID_CMD_PUP: begin
					st_nxt.cfg.powered = 1'b1;
					st_nxt.pu_busy = 1'b1;
					st_nxt.seq_cnt = SEQ_CYCLES;
				end
				SID_CMD_PDN: begin
					st_nxt.cfg.powered = 1'b0;
					st_nxt.pd_busy = 1'b1;
					st_nxt.seq_cnt = SEQ_CYCLES;
				end
				SID_CMD_STAT: st_nxt.stat_show = 1'b1;
				SID_CMD_SIGN: st_nxt.cfg.sign_on = q_data.sign_on;
				SID_CMD_ACQ:  st_nxt.cfg.acq_sel = q_data.acq_sel;
				SID_CMD_USER: st_nxt.cfg.test_mode = 1'b0;
				SID_CMD_TEST: st_nxt.cfg.test_mode = 1'b1;
				default: ;
			endcase
		end
		// pin power-down overrides the powered flag and conversion start
		if (st_r.pd_level) begin
			st_nxt.cfg.powered = 1'b0;
			st_nxt.conv_start = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_r <= '0;
			st_r.cfg <= CFG_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	always_comb begin
		device_status_word = '0;
		device_status_word[ST_PU]   = st_r.pu_busy;
		device_status_word[ST_PD]   = st_r.pd_busy;
		device_status_word[ST_CAL]  = st_r.cal_busy;
		device_status_word[ST_F12]  = !st_r.cfg.wide;
		device_status_word[ST_F16]  = st_r.cfg.wide;
		device_status_word[ST_SIGN] = st_r.cfg.sign_on;
		device_status_word[ST_MSB]  = !st_r.cfg.lsb_first;
		device_status_word[ST_TEST] = st_r.cfg.test_mode;
	end

	assign tx_word = st_r.stat_show ?
		{device_status_word, 8'h00} : st_r.word;
	assign conv_start       = st_r.conv_start;
	assign mux_address      = st_r.addr;
	assign acq_cycles       = acq_count(st_r.cfg.acq_sel);
	assign config_state     = st_r.cfg;
	assign mux_internal_tie = !EIGHT_CH;
	assign test_outputs_oe  = {7{st_r.cfg.test_mode}};

	a_conv_starts: assert property (@(posedge clk) disable iff (!rst_n)
		q_valid && q_data.cmd == SID_CMD_CONV && !st_r.pd_level
		|=> conv_start) else $error("conversion not started");
	a_acq_nostart: assert property (@(posedge clk) disable iff (!rst_n)
		q_valid && q_data.cmd == SID_CMD_ACQ |=> !conv_start)
		else $error("acquisition change started conversion");
	a_acq_value: assert property (@(posedge clk) disable iff (!rst_n)
		q_valid && q_data.cmd == SID_CMD_ACQ && q_data.acq_sel == 2'h3
		|=> acq_cycles == 6'h22) else $error("acq 34 wrong");
	a_sign_set: assert property (@(posedge clk) disable iff (!rst_n)
		q_valid && q_data.cmd == SID_CMD_SIGN
		|=> device_status_word[ST_SIGN] == $past(q_data.sign_on))
		else $error("sign flag wrong");
	a_test_mode: assert property (@(posedge clk) disable iff (!rst_n)
		q_valid && q_data.cmd == SID_CMD_TEST |=> test_outputs_oe == 7'h7f)
		else $error("test outputs not enabled");
	a_pd_pin: assert property (@(posedge clk) disable iff (!rst_n)
		st_r.pd_level |=> !config_state.powered)
		else $error("pin power down ignored");
	a_fmt_bits: assert property (@(posedge clk) disable iff (!rst_n)
		device_status_word[ST_F12] != device_status_word[ST_F16])
		else $error("format flags clash");
	a_reset_dflt: assert property (@(posedge clk)
		!rst_n |=> acq_cycles == 6'h0a && config_state.sign_on
		&& !config_state.test_mode) else $error("bad defaults");
	a_fmt_next: assert property (@(posedge clk) disable iff (!rst_n)
		q_valid && q_data.cmd == SID_CMD_CONV
		|=> config_state.wide == $past(q_data.wide))
		else $error("word length not taken");
	sequence s_cmd_cal;
		q_valid && q_data.cmd == SID_CMD_CAL;
	endsequence
	sequence s_cal_shown;
		device_status_word[ST_CAL] && !conv_start;
	endsequence
	a_cal_busy: assert property (@(posedge clk) disable iff (!rst_n)
		s_cmd_cal |=> s_cal_shown) else $error("calibration flag missing");
	sequence s_cmd_stat;
		q_valid && q_data.cmd == SID_CMD_STAT;
	endsequence
	a_stat_load: assert property (@(posedge clk) disable iff (!rst_n)
		s_cmd_stat |=> tx_word[16:8] == device_status_word)
		else $error("status not loaded for the link");
	a_pdn_busy: assert property (@(posedge clk) disable iff (!rst_n)
		q_valid && q_data.cmd == SID_CMD_PDN
		|=> device_status_word[ST_PD] && !config_state.powered)
		else $error("power down not flagged");
	a_fifo_room: assert property (@(posedge serial_clk)
		disable iff (!rst_n) lk_nxt.fire |-> fifo_ready)
		else $error("instruction dropped by full queue");
endmodule
`default_nettype wire

// ### design/sid_fifo.sv
`timescale 1ns/1ns
`default_nettype none
// gray-pointer async fifo carrying decoded instructions
module sid_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	// write side
	input  wire logic             wclk,
	input  wire logic             wrst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// read side
	input  wire logic             rclk,
	input  wire logic             rrst_n,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	// the gray full test needs a power-of-two depth of at least four
	if (WIDTH < 1 || DEPTH < 4 || (1 << AW) != DEPTH) begin : g_bad_size
		$error("fifo width or depth not supported");
	end

	function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
		return b ^ (b >> 1);
	endfunction

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0]      wptr_r, rptr_r, wgray_r, rgray_r;
	logic [AW:0]      rg_s1_r, rg_s2_r, wg_s1_r, wg_s2_r;

	// full compares own gray against read gray with two top bits flipped
	assign in_ready  = wgray_r != {~rg_s2_r[AW:AW-1], rg_s2_r[AW-2:0]};
	assign out_valid = rgray_r != wg_s2_r;
	assign out_data  = mem_r[rptr_r[AW-1:0]];

	always_ff @(posedge wclk) begin
		if (!wrst_n) begin
			wptr_r  <= '0;
			wgray_r <= '0;
			rg_s1_r <= '0;
			rg_s2_r <= '0;
		end else begin
			rg_s1_r <= rgray_r;
			rg_s2_r <= rg_s1_r;
			if (in_valid && in_ready) begin
				mem_r[wptr_r[AW-1:0]] <= in_data;
				wptr_r  <= wptr_r + 1'b1;
				wgray_r <= bin2gray(wptr_r + 1'b1);
			end
		end
	end

	always_ff @(posedge rclk) begin
		if (!rrst_n) begin
			rptr_r  <= '0;
			rgray_r <= '0;
			wg_s1_r <= '0;
			wg_s2_r <= '0;
		end else begin
			wg_s1_r <= wgray_r;
			wg_s2_r <= wg_s1_r;
			if (out_valid && out_ready) begin
				rptr_r  <= rptr_r + 1'b1;
				rgray_r <= bin2gray(rptr_r + 1'b1);
			end
		end
	end
endmodule
`default_nettype wire

// ### design/sid_pkg.sv
package sid_pkg;

	// instruction and status word widths (instruction bit 0 arrives first, status bit 8 first)
	localparam int INSTR_BITS      = 8;
	localparam int STATUS_BITS     = 9;
	// status word bit positions
	localparam int ST_PU           = 0;
	localparam int ST_PD           = 1;
	localparam int ST_CAL          = 2;
	localparam int ST_F12          = 4;
	localparam int ST_F16          = 5;
	localparam int ST_SIGN         = 6;
	localparam int ST_MSB          = 7;
	localparam int ST_TEST         = 8;
	// acquisition codes and cycle counts in conversion clocks
	localparam logic [1:0] ACQ_RESET = 2'h1;
	localparam logic [5:0] ACQ_CYC6  = 6'h06;
	localparam logic [5:0] ACQ_CYC10 = 6'h0a;
	localparam logic [5:0] ACQ_CYC18 = 6'h12;
	localparam logic [5:0] ACQ_CYC34 = 6'h22;
	// word lengths in serial clocks
	localparam logic [4:0] WLEN_12 = 5'h0c;
	localparam logic [4:0] WLEN_13 = 5'h0d;
	localparam logic [4:0] WLEN_16 = 5'h10;
	localparam logic [4:0] WLEN_17 = 5'h11;
	// calibration / power sequence length in conversion clocks
	localparam logic [7:0] SEQ_CYCLES = 8'h20;
	localparam int FIFO_DEPTH = 32;

	typedef enum logic [1:0] {
		SID_PIN_DECODE = 2'h0,
		SID_PIN_READ   = 2'h1,
		SID_PIN_IDLE   = 2'h3,
		SID_PIN_PDOWN  = 2'h2
	} sid_pinmode_e;

	typedef enum logic [3:0] {
		SID_CMD_NONE, SID_CMD_CONV, SID_CMD_CAL, SID_CMD_ZERO,
		SID_CMD_PUP, SID_CMD_PDN, SID_CMD_STAT, SID_CMD_SIGN,
		SID_CMD_ACQ, SID_CMD_USER, SID_CMD_TEST
	} sid_cmd_e;

	// decoded instruction carried from link domain
	typedef struct packed {
		sid_cmd_e   cmd;
		logic [3:0] addr;
		logic       wide;
		logic       lsb_first;
		logic       sign_on;
		logic [1:0] acq_sel;
	} sid_instr_s;

	// configuration held in system domain
	typedef struct packed {
		logic       auto_cal;
		logic       auto_zero;
		logic [1:0] acq_sel;
		logic       sign_on;
		logic       wide;
		logic       lsb_first;
		logic       test_mode;
		logic       powered;
	} sid_cfg_s;

	localparam sid_cfg_s CFG_RESET = '{auto_cal: 1'b0, auto_zero: 1'b0,
		acq_sel: ACQ_RESET, sign_on: 1'b1, wide: 1'b0, lsb_first: 1'b0,
		test_mode: 1'b0, powered: 1'b1};

endpackage

// ### test/sid_decoder_tb.sv
`timescale 1ns/1ns
`default_nettype none
module sid_decoder_tb;
	import sid_pkg::*;
	logic                   clk;
	logic                   rst_n;
	logic                   conversion_clock;
	logic [12:0]            conv_result;
	logic                   conv_result_valid;
	logic                   serial_clk;
	logic                   chip_select_n;
	logic                   read_only_sel;
	logic                   power_down_pin;
	logic                   serial_instruction_in;
	logic                   serial_data_out;
	logic [7:0]             last_rx;
	logic                   conv_start;
	logic [3:0]             mux_address;
	logic [5:0]             acq_cycles;
	sid_cfg_s               config_state;
	logic                   mux_internal_tie;
	logic [6:0]             test_outputs_oe;
	logic [STATUS_BITS-1:0] device_status_word;
	int                     miscompares = 0;
	int                     cmp_count = 0;
	int                     conv_n = 0;
	int                     cycles = 0;

	initial begin
		clk = 1'b0;
		conversion_clock = 1'b0;
		rst_n = 1'b0;
		conv_result = 13'h0a5c;
		conv_result_valid = 1'b0;
	end
	always #5 clk = ~clk;
	always #100 conversion_clock = ~conversion_clock;

	sid_host sid_host_inst (
		.serial_clk(serial_clk),
		.chip_select_n(chip_select_n),
		.read_only_sel(read_only_sel),
		.power_down_pin(power_down_pin),
		.serial_instruction_in(serial_instruction_in),
		.serial_data_out(serial_data_out)
	);

	sid_decoder #(.EIGHT_CH(1'b1)) sid_decoder_inst (
		.clk(clk),
		.rst_n(rst_n),
		.serial_clk(serial_clk),
		.chip_select_n(chip_select_n),
		.read_only_sel(read_only_sel),
		.power_down_pin(power_down_pin),
		.serial_instruction_in(serial_instruction_in),
		.serial_data_out(serial_data_out),
		.conversion_clock(conversion_clock),
		.conv_result(conv_result),
		.conv_result_valid(conv_result_valid),
		.conv_start(conv_start),
		.mux_address(mux_address),
		.acq_cycles(acq_cycles),
		.config_state(config_state),
		.mux_internal_tie(mux_internal_tie),
		.test_outputs_oe(test_outputs_oe),
		.device_status_word(device_status_word)
	);

	// converter answers one cycle after each start
	always @(posedge clk) begin
		conv_result_valid <= #1 conv_start;
		if (conv_start === 1'b1) begin
			conv_n <= conv_n + 1;
		end
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			test_done();
		end
	end

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wclk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// effect lands a few cycles after the frame through the fifo
	task automatic frame(input logic [7:0] ins, input logic ro = 1'b0,
			input logic pd = 1'b0);
		sid_host_inst.send(ins, ro, pd, last_rx);
		wclk(10);
	endtask

	task automatic t_reset();
		check(32'(config_state), 32'(CFG_RESET));
		check(32'(acq_cycles), 32'(ACQ_CYC10));
		check(32'(test_outputs_oe), 0);
		check(32'(device_status_word[8:4]), 32'h0d);
		check(32'(mux_internal_tie), 0);
		$display("test reset done");
	endtask

	task automatic t_convert();
		logic [7:0] fmt [4] = '{8'h00, 8'h80, 8'h20, 8'ha0};
		// first byte of 0a5c: sign+12 msb, 17-bit msb, lsb first
		logic [7:0] dout [4] = '{8'h00, 8'h52, 8'h05, 8'h3a};
		int n;
		for (int k = 0; k < 4; k++) begin
			n = conv_n;
			frame(fmt[k] | 8'(k * 5));
			if (k > 0) check(32'(last_rx), 32'(dout[k]));
			check(conv_n - n, 1);
			check(32'(mux_address), k * 5);
			check(32'(config_state.wide), k % 2);
			check(32'(config_state.lsb_first), k / 2);
			check(32'(device_status_word[ST_F16]), k % 2);
			check(32'(device_status_word[ST_F12]), 1 - k % 2);
			check(32'(device_status_word[ST_MSB]), 1 - k / 2);
		end
		$display("test convert done");
	endtask

	task automatic t_acq();
		logic [5:0] cyc [4] = '{ACQ_CYC6, ACQ_CYC18, ACQ_CYC10, ACQ_CYC34};
		int n;
		n = conv_n;
		for (int k = 0; k < 4; k++) begin
			frame(8'h70 | 8'(k));
			check(32'(acq_cycles), 32'(cyc[k]));
		end
		check(conv_n - n, 0);
		$display("test acquisition done");
	endtask

	task automatic t_sign();
		int n;
		n = conv_n;
		frame(8'hb0);
		check(32'(config_state.sign_on), 0);
		check(32'(device_status_word[ST_SIGN]), 0);
		frame(8'hb1);
		check(32'(config_state.sign_on), 1);
		check(32'(device_status_word[ST_SIGN]), 1);
		check(conv_n - n, 0);
		$display("test sign done");
	endtask

	task automatic t_mode();
		frame(8'hfb);
		check(32'(test_outputs_oe), 32'h7f);
		check(32'(config_state.test_mode), 1);
		check(32'(device_status_word[ST_TEST]), 1);
		frame(8'hf0);
		check(32'(test_outputs_oe), 0);
		check(32'(device_status_word[ST_TEST]), 0);
		$display("test mode done");
	endtask

	// status appears on the link during the second read status frame
	task automatic t_status();
		frame(8'h30);
		frame(8'h30);
		check(32'(last_rx), 32'((1 << ST_F16 | 1 << ST_SIGN) >> 1));
		$display("test status done");
	endtask

	// sequences run on the slow conversion clock: 32 of them
	task automatic t_cmds();
		frame(8'h10);
		wclk(30);
		check(32'(device_status_word[ST_CAL]), 1);
		wclk(900);
		check(32'(device_status_word[ST_CAL]), 0);
		frame(8'h90);
		check(32'(config_state.auto_zero), 1);
		frame(8'hd0);
		wclk(30);
		check(32'(device_status_word[ST_PD]), 1);
		wclk(900);
		check(32'(config_state.powered), 0);
		frame(8'h50);
		wclk(30);
		check(32'(device_status_word[ST_PU]), 1);
		wclk(900);
		check(32'(config_state.powered), 1);
		$display("test commands done");
	endtask

	task automatic t_refused();
		int n;
		n = conv_n;
		frame(8'h70, 1'b1, 1'b0);
		check(32'(acq_cycles), 32'(ACQ_CYC34));
		frame(8'h05, 1'b1, 1'b0);
		check(conv_n - n, 0);
		frame(8'h70, 1'b0, 1'b1);
		check(32'(acq_cycles), 32'(ACQ_CYC34));
		check(32'(config_state.powered), 0);
		check(conv_n - n, 0);
		frame(8'h70);
		check(32'(acq_cycles), 32'(ACQ_CYC6));
		$display("test refused done");
	endtask

	initial begin
		sid_host_inst.idle_tick();
		repeat (16) @(posedge clk);
		#1 rst_n = 1'b1;
		wclk(2);
		t_reset();
		t_convert();
		t_acq();
		t_sign();
		t_mode();
		t_status();
		t_cmds();
		t_refused();
		test_done();
	end
endmodule
`default_nettype wire

// ### test/sid_host.sv
`timescale 1ns/1ns
`default_nettype none
// host serial controller: serial clock runs inside frames and for one idle tick
module sid_host (
	// serial link
	output var logic serial_clk,
	output var logic chip_select_n,
	output var logic read_only_sel,
	output var logic power_down_pin,
	output var logic serial_instruction_in,
	// data back from the device
	input  wire logic serial_data_out
);
	initial begin
		serial_clk = 1'b0;
		chip_select_n = 1'b1;
		read_only_sel = 1'b0;
		power_down_pin = 1'b0;
		serial_instruction_in = 1'b0;
	end
	// single clock with select high, so link logic sees reset
	task automatic idle_tick();
		#7 serial_clk = 1'b1;
		#8 serial_clk = 1'b0;
	endtask
	// strobed frame: eight clocks suffice because select is cycled
	task automatic send(input logic [7:0] ins, input logic ro,
			input logic pd, output logic [7:0] rx);
		read_only_sel = ro;
		power_down_pin = pd;
		#5 chip_select_n = 1'b0;
		for (int k = 0; k < 8; k++) begin
			serial_instruction_in = ins[k];
			#7 serial_clk = 1'b1;
			#8 serial_clk = 1'b0;
			// output bit settled since the rising edge, MSB first
			rx = {rx[6:0], serial_data_out};
		end
		#5 chip_select_n = 1'b1;
		// released line must not keep showing the last bit
		serial_instruction_in = ~ins[7];
		read_only_sel = 1'b0;
		power_down_pin = 1'b0;
	endtask
endmodule
`default_nettype wire
